// ### pkg/ext_alu_pkg.sv
// Overview of operation
// - Full memory address reaches any data section
// - Left rotate wraps bit 7 into bit 0
// - Left rotate via carry, only carry changes
// - Right rotate wraps bit 0 into bit 7
// - Right rotate via carry, only carry changes
// - Working minus operand minus inverted carry
// - Carry cleared on negative, else set
// - Subtracts update six arithmetic flags
// - Plain subtract without borrow, either destination
// - Memory-destination subtracts store in memory
// - Taken skip costs one extra dummy cycle
// - Decrement, write back, skip on zero
// - Increment, write back, skip on zero
// - Working variants test working value, memory untouched
// - Set byte to ones or one bit
// - Bit test skips when selected bit is one
// - Skip when whole operand is non-zero
// - Skip when operand equals zero
// - Nibble swap in memory, no flags
// - Nibble swap to working, memory untouched
// - Copy operand to working, skip on zero
`default_nettype none
package ext_alu_pkg;
   localparam int ADDR_W = 16;
   localparam logic [7:0] ONES = 8'hFF;
   localparam logic [7:0] ZERO = 8'h00;
   // ----------------------------------------
   // Register port map
   // ----------------------------------------
   localparam logic [1:0] OFF_WORKING = 2'h0;
   localparam logic [1:0] OFF_FLAGS = 2'h1;
   localparam logic [1:0] OFF_STATUS = 2'h2;
   localparam logic [7:0] WORKING_RST = 8'h00;
   localparam logic [5:0] FLAGS_RST = 6'h00;
   // ----------------------------------------
   // Flag positions
   // ----------------------------------------
   localparam int F_CARRY = 0;
   localparam int F_HALF = 1;
   localparam int F_ZERO = 2;
   localparam int F_WRAP = 3;
   localparam int F_SCMP = 4;
   localparam int F_CZERO = 5;
   // ----------------------------------------
   // Operation codes
   // ----------------------------------------
   typedef enum logic [4:0] {
      OP_ROTATE_LEFT_MEM = 5'h00,
      OP_ROTATE_LEFT_TO_WORKING = 5'h01,
      OP_ROTATE_LEFT_THRU_CARRY = 5'h02,
      OP_ROTATE_LEFT_CARRY_TO_WORKING = 5'h03,
      OP_ROTATE_RIGHT_MEM = 5'h04,
      OP_ROTATE_RIGHT_TO_WORKING = 5'h05,
      OP_ROTATE_RIGHT_THRU_CARRY = 5'h06,
      OP_ROTATE_RIGHT_CARRY_TO_WORKING = 5'h07,
      OP_SUBTRACT_BORROW_TO_WORKING = 5'h08,
      OP_SUBTRACT_BORROW_TO_MEM = 5'h09,
      OP_SUBTRACT_TO_WORKING = 5'h0A,
      OP_SUBTRACT_TO_MEM = 5'h0B,
      OP_DECREMENT_SKIP_ZERO = 5'h0C,
      OP_DECREMENT_SKIP_ZERO_TO_WORKING = 5'h0D,
      OP_INCREMENT_SKIP_ZERO = 5'h0E,
      OP_INCREMENT_SKIP_ZERO_TO_WORKING = 5'h0F,
      OP_SET_BYTE = 5'h10,
      OP_SET_BIT = 5'h11,
      OP_SKIP_WHEN_NONZERO = 5'h12,
      OP_SKIP_WHEN_BIT_SET = 5'h13,
      OP_SKIP_WHEN_ZERO = 5'h14,
      OP_COPY_THEN_SKIP_ZERO = 5'h15,
      OP_NIBBLE_EXCHANGE = 5'h16,
      OP_NIBBLE_EXCHANGE_TO_WORKING = 5'h17
   } op_t;
endpackage : ext_alu_pkg
`default_nettype wire

// ### logic/sub_flag_unit.sv
`timescale 1ns/100ps
`default_nettype none
module sub_flag_unit (
   // Operands
   input wire logic [7:0] i_minuend,
   input wire logic [7:0] i_subtrahend,
   input wire logic i_borrow_in,
   input wire logic i_chained,
   input wire logic i_czero_in,
   // Result
   output logic [7:0] o_diff,
   output logic [5:0] o_flags
);
   logic [8:0] full;
   logic [4:0] low;
   always_comb begin
      full = {1'b0, i_minuend} - {1'b0, i_subtrahend} - {8'h00, i_borrow_in};
      low = {1'b0, i_minuend[3:0]} - {1'b0, i_subtrahend[3:0]} - {4'h0, i_borrow_in};
      o_diff = full[7:0];
      o_flags = ext_alu_pkg::FLAGS_RST;
      o_flags[ext_alu_pkg::F_CARRY] = ~full[8];
      o_flags[ext_alu_pkg::F_HALF] = ~low[4];
      o_flags[ext_alu_pkg::F_ZERO] = (full[7:0] == ext_alu_pkg::ZERO);
      o_flags[ext_alu_pkg::F_WRAP] = (i_minuend[7] != i_subtrahend[7])
         && (full[7] != i_minuend[7]);
      o_flags[ext_alu_pkg::F_SCMP] = o_flags[ext_alu_pkg::F_WRAP] ^ full[7];
      // Chained form keeps zero only if the earlier part was zero too
      o_flags[ext_alu_pkg::F_CZERO] = o_flags[ext_alu_pkg::F_ZERO]
         & (~i_chained | i_czero_in);
   end
endmodule : sub_flag_unit
`default_nettype wire

// ### logic/extended_rotate_sub_skip_alu.sv
// Added by the designer: the register addresses and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
module extended_rotate_sub_skip_alu (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Instruction from decoder
   input wire logic i_op_valid,
   input wire logic [4:0] i_opcode,
   input wire logic [2:0] i_bit_sel,
   input wire logic [ext_alu_pkg::ADDR_W-1:0] i_mem_addr,
   output logic o_ready,
   output logic o_done,
   output logic o_skip,
   output logic o_dummy,
   // Data memory
   output logic [ext_alu_pkg::ADDR_W-1:0] o_mem_addr,
   output logic o_mem_rd,
   input wire logic [7:0] i_mem_rdata,
   output logic o_mem_wr,
   output logic [7:0] o_mem_wdata,
   // Register port
   input wire logic [1:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   // Core state
   output logic [7:0] o_working,
   output logic [5:0] o_flags
);
   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_EXEC = 4'b0100,
      ST_DUMMY = 4'b1000
   } state_t;

   state_t state_r;
   state_t state_nxt;
   ext_alu_pkg::op_t op_r;
   logic [2:0] bit_r;
   logic [7:0] working_r;
   logic [5:0] flags_r;

   function automatic logic is_zero(input logic [7:0] v);
      return v == ext_alu_pkg::ZERO;
   endfunction : is_zero

   function automatic logic [7:0] bit_mask(input logic [2:0] sel);
      return 8'h01 << sel;
   endfunction : bit_mask

   logic take;
   // Gated by ready too, so a request in the first cycle after reset is refused
   assign take = i_op_valid && o_ready && (state_r == ST_IDLE);

   // ----------------------------------------
   // Execute stage
   // ----------------------------------------
   logic [7:0] opnd;
   logic [7:0] res_nxt;
   logic to_mem;
   logic to_work;
   logic carry_upd;
   logic carry_nxt;
   logic sub_upd;
   logic skip_nxt;
   logic sub_borrow;
   logic sub_chain;
   logic [7:0] sub_diff;
   logic [5:0] sub_flags;
   logic carry_in;

   assign opnd = i_mem_rdata;
   assign carry_in = flags_r[ext_alu_pkg::F_CARRY];

   always_comb begin
      sub_borrow = 1'b0;
      sub_chain = 1'b0;
      if (op_r == ext_alu_pkg::OP_SUBTRACT_BORROW_TO_WORKING
          || op_r == ext_alu_pkg::OP_SUBTRACT_BORROW_TO_MEM) begin
         sub_borrow = ~carry_in;
         sub_chain = 1'b1;
      end
   end

   sub_flag_unit u_sub (
      .i_minuend(working_r),
      .i_subtrahend(opnd),
      .i_borrow_in(sub_borrow),
      .i_chained(sub_chain),
      .i_czero_in(flags_r[ext_alu_pkg::F_CZERO]),
      .o_diff(sub_diff),
      .o_flags(sub_flags)
   );

   always_comb begin
      res_nxt = opnd;
      to_mem = 1'b0;
      to_work = 1'b0;
      carry_upd = 1'b0;
      carry_nxt = carry_in;
      sub_upd = 1'b0;
      skip_nxt = 1'b0;
      unique case (op_r)
         ext_alu_pkg::OP_ROTATE_LEFT_MEM,
         ext_alu_pkg::OP_ROTATE_LEFT_TO_WORKING: begin
            res_nxt = {opnd[6:0], opnd[7]};
            to_mem = (op_r == ext_alu_pkg::OP_ROTATE_LEFT_MEM);
            to_work = ~to_mem;
         end
         ext_alu_pkg::OP_ROTATE_LEFT_THRU_CARRY,
         ext_alu_pkg::OP_ROTATE_LEFT_CARRY_TO_WORKING: begin
            res_nxt = {opnd[6:0], carry_in};
            carry_upd = 1'b1;
            carry_nxt = opnd[7];
            to_mem = (op_r == ext_alu_pkg::OP_ROTATE_LEFT_THRU_CARRY);
            to_work = ~to_mem;
         end
         ext_alu_pkg::OP_ROTATE_RIGHT_MEM,
         ext_alu_pkg::OP_ROTATE_RIGHT_TO_WORKING: begin
            res_nxt = {opnd[0], opnd[7:1]};
            to_mem = (op_r == ext_alu_pkg::OP_ROTATE_RIGHT_MEM);
            to_work = ~to_mem;
         end
         ext_alu_pkg::OP_ROTATE_RIGHT_THRU_CARRY,
         ext_alu_pkg::OP_ROTATE_RIGHT_CARRY_TO_WORKING: begin
            res_nxt = {carry_in, opnd[7:1]};
            carry_upd = 1'b1;
            carry_nxt = opnd[0];
            to_mem = (op_r == ext_alu_pkg::OP_ROTATE_RIGHT_THRU_CARRY);
            to_work = ~to_mem;
         end
         ext_alu_pkg::OP_SUBTRACT_BORROW_TO_WORKING,
         ext_alu_pkg::OP_SUBTRACT_TO_WORKING: begin
            res_nxt = sub_diff;
            sub_upd = 1'b1;
            to_work = 1'b1;
         end
         ext_alu_pkg::OP_SUBTRACT_BORROW_TO_MEM,
         ext_alu_pkg::OP_SUBTRACT_TO_MEM: begin
            res_nxt = sub_diff;
            sub_upd = 1'b1;
            to_mem = 1'b1;
         end
         ext_alu_pkg::OP_DECREMENT_SKIP_ZERO,
         ext_alu_pkg::OP_DECREMENT_SKIP_ZERO_TO_WORKING: begin
            res_nxt = opnd - 8'h01;
            skip_nxt = is_zero(res_nxt);
            to_mem = (op_r == ext_alu_pkg::OP_DECREMENT_SKIP_ZERO);
            to_work = ~to_mem;
         end
         ext_alu_pkg::OP_INCREMENT_SKIP_ZERO,
         ext_alu_pkg::OP_INCREMENT_SKIP_ZERO_TO_WORKING: begin
            res_nxt = opnd + 8'h01;
            skip_nxt = is_zero(res_nxt);
            to_mem = (op_r == ext_alu_pkg::OP_INCREMENT_SKIP_ZERO);
            to_work = ~to_mem;
         end
         ext_alu_pkg::OP_SET_BYTE: begin
            res_nxt = ext_alu_pkg::ONES;
            to_mem = 1'b1;
         end
         ext_alu_pkg::OP_SET_BIT: begin
            res_nxt = opnd | bit_mask(bit_r);
            to_mem = 1'b1;
         end
         ext_alu_pkg::OP_SKIP_WHEN_NONZERO: begin
            skip_nxt = ~is_zero(opnd);
         end
         ext_alu_pkg::OP_SKIP_WHEN_BIT_SET: begin
            skip_nxt = |(opnd & bit_mask(bit_r));
         end
         ext_alu_pkg::OP_SKIP_WHEN_ZERO: begin
            skip_nxt = is_zero(opnd);
         end
         ext_alu_pkg::OP_COPY_THEN_SKIP_ZERO: begin
            to_work = 1'b1;
            skip_nxt = is_zero(opnd);
         end
         ext_alu_pkg::OP_NIBBLE_EXCHANGE,
         ext_alu_pkg::OP_NIBBLE_EXCHANGE_TO_WORKING: begin
            res_nxt = {opnd[3:0], opnd[7:4]};
            to_mem = (op_r == ext_alu_pkg::OP_NIBBLE_EXCHANGE);
            to_work = ~to_mem;
         end
         default: begin
            // Unlisted codes retire as a plain no-op
            res_nxt = opnd;
         end
      endcase
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_comb begin
      state_nxt = state_r;
      unique case (state_r)
         ST_IDLE: begin
            if (take) begin
               state_nxt = ST_FETCH;
            end
         end
         ST_FETCH: begin
            state_nxt = ST_EXEC;
         end
         ST_EXEC: begin
            state_nxt = skip_nxt ? ST_DUMMY : ST_IDLE;
         end
         ST_DUMMY: begin
            state_nxt = ST_IDLE;
         end
         default: begin
            state_nxt = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         state_r <= ST_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // ----------------------------------------
   // Instruction capture
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         op_r <= ext_alu_pkg::OP_SKIP_WHEN_ZERO;
         bit_r <= 3'h0;
      end else if (take) begin
         op_r <= ext_alu_pkg::op_t'(i_opcode);
         bit_r <= i_bit_sel;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_ready <= 1'b0;
      end else begin
         o_ready <= (state_nxt == ST_IDLE);
      end
   end

   // ----------------------------------------
   // Data memory port
   // ----------------------------------------
   // Address kept for the whole instruction so the write hits the same byte
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_mem_addr <= '0;
      end else if (take) begin
         o_mem_addr <= i_mem_addr;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_mem_rd <= 1'b0;
         o_mem_wr <= 1'b0;
         o_mem_wdata <= ext_alu_pkg::ZERO;
      end else begin
         o_mem_rd <= take;
         o_mem_wr <= (state_r == ST_EXEC) && to_mem;
         if ((state_r == ST_EXEC) && to_mem) begin
            o_mem_wdata <= res_nxt;
         end
      end
   end

   // ----------------------------------------
   // Completion and skip signalling
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_done <= 1'b0;
         o_skip <= 1'b0;
         o_dummy <= 1'b0;
      end else begin
         o_done <= (state_r == ST_EXEC);
         o_skip <= (state_r == ST_EXEC) && skip_nxt;
         o_dummy <= (state_r == ST_DUMMY);
      end
   end

   // ----------------------------------------
   // Working register and flags
   // ----------------------------------------
   // Execute wins over a software write in the same cycle; the port is
   // meant for setup and debug, not racing a running instruction.
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         working_r <= ext_alu_pkg::WORKING_RST;
      end else if ((state_r == ST_EXEC) && to_work) begin
         working_r <= res_nxt;
      end else if (i_reg_wr && i_reg_addr == ext_alu_pkg::OFF_WORKING) begin
         working_r <= i_reg_wdata;
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         flags_r <= ext_alu_pkg::FLAGS_RST;
      end else if ((state_r == ST_EXEC) && sub_upd) begin
         flags_r <= sub_flags;
      end else if ((state_r == ST_EXEC) && carry_upd) begin
         flags_r[ext_alu_pkg::F_CARRY] <= carry_nxt;
      end else if (i_reg_wr && i_reg_addr == ext_alu_pkg::OFF_FLAGS) begin
         flags_r <= i_reg_wdata[5:0];
      end
   end

   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_working <= ext_alu_pkg::WORKING_RST;
         o_flags <= ext_alu_pkg::FLAGS_RST;
      end else begin
         o_working <= working_r;
         o_flags <= flags_r;
      end
   end

   // ----------------------------------------
   // Register read
   // ----------------------------------------
   always_ff @(posedge i_clock) begin
      if (i_srst) begin
         o_reg_rdata <= ext_alu_pkg::ZERO;
      end else if (i_reg_rd) begin
         unique case (i_reg_addr)
            ext_alu_pkg::OFF_WORKING: o_reg_rdata <= working_r;
            ext_alu_pkg::OFF_FLAGS: o_reg_rdata <= {2'b00, flags_r};
            ext_alu_pkg::OFF_STATUS: o_reg_rdata <= {4'h0, state_r};
            default: o_reg_rdata <= ext_alu_pkg::ZERO;
         endcase
      end else begin
         o_reg_rdata <= ext_alu_pkg::ZERO;
      end
   end
endmodule : extended_rotate_sub_skip_alu
`default_nettype wire

// ### tb/data_mem.sv
`timescale 1ns/100ps
`default_nettype none
module data_mem (
   // Core side
   input wire logic i_clock,
   input wire logic [ext_alu_pkg::ADDR_W-1:0] i_addr,
   input wire logic i_rd,
   input wire logic i_wr,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:65535];
   initial o_rdata = 8'h00;
   // Stale data is inverted so a late sample cannot pass
   always @(posedge i_clock) begin
      o_rdata <= i_rd ? mem[i_addr] : ~o_rdata;
      if (i_wr) begin
         mem[i_addr] <= i_wdata;
      end
   end
endmodule : data_mem
`default_nettype wire

// ### tb/ext_alu_properties.sv
`timescale 1ns/100ps
`default_nettype none
module alu_checker (
   // Clock and reset
   input wire logic i_clock,
   input wire logic i_srst,
   // Instruction
   input wire logic i_op_valid,
   input wire logic [4:0] i_opcode,
   input wire logic [2:0] i_bit_sel,
   input wire logic [ext_alu_pkg::ADDR_W-1:0] i_mem_addr,
   input wire logic o_ready,
   input wire logic o_done,
   input wire logic o_skip,
   input wire logic o_dummy,
   // Memory and state
   input wire logic [ext_alu_pkg::ADDR_W-1:0] o_mem_addr,
   input wire logic o_mem_rd,
   input wire logic [7:0] i_mem_rdata,
   input wire logic o_mem_wr,
   input wire logic [7:0] o_mem_wdata,
   input wire logic i_reg_wr,
   input wire logic [7:0] o_working,
   input wire logic [5:0] o_flags
);
   logic [4:0] op_r;
   logic [2:0] sel_r;
   logic [7:0] rd_r;
   logic rd_d_r;
   default clocking @(posedge i_clock); endclocking
   default disable iff (i_srst);
   // ----
   // Operand and opcode as seen by the exec cycle
   // ----
   always_ff @(posedge i_clock) begin
      rd_d_r <= o_mem_rd;
      if (rd_d_r) begin
         rd_r <= i_mem_rdata;
      end
      if (i_op_valid && o_ready) begin
         op_r <= i_opcode;
         sel_r <= i_bit_sel;
      end
   end
   sequence take_s;
      i_op_valid && o_ready;
   endsequence
   sequence done_op(logic [4:0] k);
      o_done && op_r == k;
   endsequence
   sequence wr_op(logic [4:0] k);
      o_mem_wr && op_r == k;
   endsequence
   take_read_a: assert property (
      take_s |=> o_mem_rd && o_mem_addr == $past(i_mem_addr))
      else $error("operand read missing");
   retire_time_a: assert property (take_s |=> !o_ready [*2] ##1 o_done)
      else $error("retire not three cycles after take");
   skip_dummy_a: assert property (
      o_skip |-> o_done ##1 (o_dummy && o_ready && !o_mem_wr))
      else $error("dummy cycle wrong after skip");
   dummy_quiet_a: assert property (
      o_dummy && !$past(i_reg_wr) |=> $stable(o_working) && $stable(o_flags))
      else $error("dummy cycle changed state");
   ready_back_a: assert property (o_done |-> o_ready == !o_skip)
      else $error("ready wrong at retire");
   rotl_mem_a: assert property (wr_op(5'h00) |-> o_mem_wdata == {rd_r[6:0], rd_r[7]})
      else $error("left rotate result wrong");
   dec_skip_a: assert property (done_op(5'h0C) |-> o_skip == (o_mem_wdata == 8'h00))
      else $error("decrement skip wrong");
   set_byte_a: assert property (wr_op(5'h10) |-> o_mem_wdata == 8'hFF)
      else $error("set byte not all ones");
   bit_skip_a: assert property (done_op(5'h13) |-> o_skip == rd_r[sel_r])
      else $error("bit test skip wrong");
   zero_skip_a: assert property (done_op(5'h14) |-> o_skip == (rd_r == 8'h00))
      else $error("zero skip wrong");
   swap_mem_a: assert property (
      wr_op(5'h16) |-> o_mem_wdata == {rd_r[3:0], rd_r[7:4]})
      else $error("nibble swap wrong");
endmodule : alu_checker
bind extended_rotate_sub_skip_alu alu_checker i_alu_checker (.i_clock, .i_srst, .i_op_valid,
   .i_opcode, .i_bit_sel, .i_mem_addr, .o_ready, .o_done, .o_skip, .o_dummy, .o_mem_addr,
   .o_mem_rd, .i_mem_rdata, .o_mem_wr, .o_mem_wdata, .i_reg_wr, .o_working, .o_flags);
`default_nettype wire

// ### tb/test_extended_rotate_sub_skip_alu.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin fail_count++; \
   $display("ERROR %s exp %h got %h", nm, ex, got); end end
module test_extended_rotate_sub_skip_alu;
   logic i_clock = 1'b0;
   logic i_srst = 1'b1;
   logic op_valid = 1'b0;
   logic [4:0] opcode = 5'h00;
   logic [2:0] bit_sel = 3'h0;
   logic [15:0] mem_addr = 16'h0000;
   logic [1:0] reg_addr = 2'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic ready, done, skip, dummy, mem_rd, mem_wr;
   logic [15:0] mem_a;
   logic [7:0] rdata, wdata, reg_rdata, working;
   logic [5:0] flags, fe;
   int fail_count = 0;
   int cmp_count = 0;
   // Operand sets: borrow, wrap, zero, and both ends of memory
   logic [7:0] wv [5] = '{8'h10, 8'h00, 8'h80, 8'h80, 8'h3C};
   logic [7:0] mv [5] = '{8'h01, 8'hFF, 8'h00, 8'h01, 8'h3C};
   logic [5:0] fv [5] = '{6'h00, 6'h21, 6'h01, 6'h20, 6'h21};
   logic [15:0] av [5] = '{16'h0000, 16'hFFFF, 16'h8123, 16'h0100, 16'h7FFE};
   logic [2:0] bv [5] = '{3'h0, 3'h7, 3'h3, 3'h1, 3'h2};
   always #5 i_clock = ~i_clock;
   extended_rotate_sub_skip_alu i_extended_rotate_sub_skip_alu (.i_clock(i_clock),
      .i_srst(i_srst), .i_op_valid(op_valid), .i_opcode(opcode), .i_bit_sel(bit_sel),
      .i_mem_addr(mem_addr), .o_ready(ready), .o_done(done), .o_skip(skip), .o_dummy(dummy),
      .o_mem_addr(mem_a), .o_mem_rd(mem_rd), .i_mem_rdata(rdata), .o_mem_wr(mem_wr),
      .o_mem_wdata(wdata), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
      .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .o_working(working), .o_flags(flags));
   data_mem i_data_mem (.i_clock(i_clock), .i_addr(mem_a), .i_rd(mem_rd), .i_wr(mem_wr),
      .i_wdata(wdata), .o_rdata(rdata));
   // ----
   // Register port
   // ----
   task automatic reg_write(input logic [1:0] a, input logic [7:0] d);
      @(posedge i_clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge i_clock);
      reg_wr <= 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [1:0] a, output logic [7:0] d);
      @(posedge i_clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge i_clock);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask : reg_read
   // ----
   // Expected outcome of one instruction
   // ----
   function automatic void calc(input logic [4:0] op, input int v, output logic [7:0] r,
      output logic tow, output logic wr, output logic sk);
      logic [8:0] d;
      logic [7:0] m;
      logic c, bw, ov;
      m = mv[v];
      c = fe[0];
      r = m;
      tow = op[0];
      wr = !op[0];
      sk = 1'b0;
      case (op)
         5'h00, 5'h01: r = {m[6:0], m[7]};
         5'h02, 5'h03: begin
            r = {m[6:0], c};
            fe[0] = m[7];
         end
         5'h04, 5'h05: r = {m[0], m[7:1]};
         5'h06, 5'h07: begin
            r = {c, m[7:1]};
            fe[0] = m[0];
         end
         5'h08, 5'h09, 5'h0A, 5'h0B: begin
            bw = !op[1] && !c;
            d = {1'b0, wv[v]} - {1'b0, m} - 9'(bw);
            r = d[7:0];
            ov = (wv[v][7] != m[7]) && (r[7] != wv[v][7]);
            fe = {(r == 8'h00) && (op[1] || fe[5]), ov ^ r[7], ov, r == 8'h00,
               5'(wv[v][3:0]) >= 5'(m[3:0]) + 5'(bw), !d[8]};
            tow = !op[0];
            wr = op[0];
         end
         5'h0C, 5'h0D: begin
            r = m - 8'h01;
            sk = r == 8'h00;
         end
         5'h0E, 5'h0F: begin
            r = m + 8'h01;
            sk = r == 8'h00;
         end
         5'h10: r = 8'hFF;
         5'h11: begin
            r = m | (8'h01 << bv[v]);
            tow = 1'b0;
            wr = 1'b1;
         end
         5'h12, 5'h13, 5'h14, 5'h15: begin
            sk = op == 5'h12 ? m != 8'h00 : op == 5'h13 ? m[bv[v]] : m == 8'h00;
            tow = op == 5'h15;
            wr = 1'b0;
         end
         5'h16, 5'h17: r = {m[3:0], m[7:4]};
         default: begin
            tow = 1'b0;
            wr = 1'b0;
         end
      endcase
   endfunction : calc
   task automatic run(input logic [4:0] op, input int v);
      logic [7:0] r;
      logic tow, wr, sk, got;
      int n;
      fe = fv[v];
      reg_write(2'h0, wv[v]);
      reg_write(2'h1, 8'(fe));
      i_data_mem.mem[av[v]] = mv[v];
      calc(op, v, r, tow, wr, sk);
      #1;
      `CHK("ready", 1'b1, ready)
      @(posedge i_clock);
      op_valid <= 1'b1;
      opcode <= op;
      bit_sel <= bv[v];
      mem_addr <= av[v];
      @(posedge i_clock);
      op_valid <= 1'b0;
      n = 0;
      do begin
         @(posedge i_clock);
         #1;
         n++;
      end while (done !== 1'b1 && n < 8);
      got = skip;
      `CHK("done", 1'b1, done)
      `CHK("skip", sk, got)
      @(posedge i_clock);
      #1;
      `CHK("dummy", sk, dummy)
      @(posedge i_clock);
      #1;
      `CHK("memory", wr ? r : mv[v], i_data_mem.mem[av[v]])
      `CHK("working", tow ? r : wv[v], working)
      `CHK("flags", fe, flags)
   endtask : run
   task end_sim;
      if (fail_count == 0 && cmp_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_sim
   initial begin
      #100000;
      fail_count++;
      end_sim;
   end
   initial begin
      logic [7:0] d;
      repeat (4) @(posedge i_clock);
      i_srst <= 1'b0;
      repeat (2) @(posedge i_clock);
      #1;
      `CHK("working_reset", 8'h00, working)
      `CHK("flags_reset", 6'h00, flags)
      reg_read(2'h2, d);
      `CHK("state_idle", 8'h01, d)
      reg_read(2'h3, d);
      `CHK("unmapped", 8'h00, d)
      for (int v = 0; v < 5; v++) begin
         for (int op = 0; op < 24; op++) begin
            run(5'(op), v);
         end
      end
      run(5'h1F, 0);
      reg_read(2'h1, d);
      `CHK("flags_read", fe, d[5:0])
      end_sim;
   end
endmodule : test_extended_rotate_sub_skip_alu
`default_nettype wire
